/* include/pod_pkg.sv */
// Constants for the port output mode and direction block.
// Assumes a 32-bit AXI4-Lite register bus with 12 address bits.
package pod_pkg;

    // Bus widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register byte addresses
    localparam logic [11:0] OFF_PIN_DATA = 12'h000;
    localparam logic [11:0] OFF_DIR = 12'h0F8;
    localparam logic [11:0] OFF_CFG = 12'hF00;

    // Output configuration fields
    localparam int CFG_P4_BIT = 3;
    localparam int CFG_P0_BIT = 2;
    localparam int CFG_P1_BIT = 1;
    localparam int CFG_CMP_BIT = 0;
    localparam logic [3:0] CFG_RST = 4'b1110;
    localparam logic [7:0] CFG_RD_ONES = 8'hF7;

    // Direction fields
    localparam int DIR_HI_BIT = 6;
    localparam int DIR_P1_BIT = 3;
    localparam int DIR_LO_BIT = 0;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] DIR_RD_ONES = 8'hB0;
    localparam logic [7:0] DIR_WR_MASK = 8'h49;

    // Port 0 data and pin numbering
    localparam logic [7:0] PIN_DATA_RST = 8'h00;
    localparam int TOP_PIN = 7;
    localparam int HI_NIBBLE_LSB = 4;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : pod_pkg

/* verilog/pod_port_cfg.sv */
// Port 0 data, port 0/1 direction and port output mode configuration,
// reached over an AXI4-Lite slave.
// Assumes pin inputs synchronous to REF_CLK and a pad ring that resolves
// each pin from its output and output enable.
//
// Operation
// - Config bit 3 selects port 4 push/pull
// - Config bit 2 port 0 mode, reads 1
// - Config bit 1 port 1 mode, reads 1
// - Config bit 0 routes comparator outputs, reads 1
// - Config bits 7 to 4 read ones
// - Config survives stop mode recovery
// - Small package ignores port 4/1 mode writes
// - Direction bit 6 sets port 0 upper nibble
// - Direction bit 0 sets port 0 lower nibble
// - Direction bit 3 sets port 1, large only
// - Direction bits 7, 5, 4 read ones
// - Data read returns actual pin levels
// - Data write drives only output pins
// - Pin 7 general I/O only without UART transmit
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module pod_port_cfg
    import pod_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RESETN,
    // AXI4-Lite write address
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [pod_pkg::ADDR_W-1:0] AWADDR,
    input wire logic [2:0] AWPROT,
    // AXI4-Lite write data
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [pod_pkg::DATA_W-1:0] WDATA,
    input wire logic [3:0] WSTRB,
    // AXI4-Lite write response
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    // AXI4-Lite read address
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [pod_pkg::ADDR_W-1:0] ARADDR,
    input wire logic [2:0] ARPROT,
    // AXI4-Lite read data
    output logic RVALID,
    input wire logic RREADY,
    output logic [pod_pkg::DATA_W-1:0] RDATA,
    output logic [1:0] RRESP,
    // Device state
    input wire logic PKG_LARGE,
    input wire logic UART_TX_EN,
    // Port 0 pins
    input wire logic [7:0] P0_IN,
    output logic [7:0] P0_OUT,
    output logic [7:0] P0_OE,
    // Mode outputs to other ports
    output logic PORT4_PUSH_PULL,
    output logic PORT1_PUSH_PULL,
    output logic PORT1_INPUT,
    output logic CMP_ROUTE_EN
);
    import pod_pkg::*;

    // Registers
    logic [3:0] cfg_ff;
    logic [7:0] dir_ff;
    logic [7:0] data_ff;
    logic [7:0] p0_out_ff;
    logic [7:0] p0_oe_ff;

    // Bus state
    logic awready_ff;
    logic wready_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [ADDR_W-1:0] waddr_ff;
    logic [7:0] wdata_ff;
    logic wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [1:0] rresp_ff;

    // Handshakes
    wire aw_fire = AWVALID & awready_ff;
    wire w_fire = WVALID & wready_ff;
    wire ar_fire = ARVALID & arready_ff;
    wire b_done = bvalid_ff & BREADY;
    wire r_done = rvalid_ff & RREADY;
    // A write executes only once the previous response has been taken
    wire wr_go = aw_got_ff & w_got_ff & ~bvalid_ff;
    wire nxt_aw_got = (aw_got_ff | aw_fire) & ~wr_go;
    wire nxt_w_got = (w_got_ff | w_fire) & ~wr_go;
    wire nxt_rvalid = ar_fire | (rvalid_ff & ~RREADY);

    // Write decode; only the low byte lane carries register bits
    // Config sits at its linear address so it does not shadow port 0 data
    wire wr_data = wr_go & (waddr_ff == OFF_PIN_DATA);
    wire wr_dir = wr_go & (waddr_ff == OFF_DIR);
    wire wr_cfg = wr_go & (waddr_ff == OFF_CFG);
    wire wr_hit = wr_data | wr_dir | wr_cfg;
    wire wr_en = wr_hit & wstrb_ff;

    // Small packages keep the port 4 and port 1 fields
    wire [3:0] cfg_big_only = 4'((1 << CFG_P4_BIT) | (1 << CFG_P1_BIT));
    wire [7:0] dir_big_only = 8'(1 << DIR_P1_BIT);
    wire [3:0] cfg_mask = PKG_LARGE ? 4'b1111 : ~cfg_big_only;
    wire [7:0] dir_mask = PKG_LARGE ? DIR_WR_MASK : (DIR_WR_MASK & ~dir_big_only);
    wire [3:0] nxt_cfg = (cfg_ff & ~cfg_mask) | (wdata_ff[3:0] & cfg_mask);
    wire [7:0] nxt_dir = (dir_ff & ~dir_mask) | (wdata_ff & dir_mask);

    // Read decode with forced-one fields
    // Read data is latched at the address handshake, so pins are sampled there
    wire rd_data = (ARADDR == OFF_PIN_DATA);
    wire rd_dir = (ARADDR == OFF_DIR);
    wire rd_cfg = (ARADDR == OFF_CFG);
    wire [7:0] cfg_view = CFG_RD_ONES | {4'h0, cfg_ff[CFG_P4_BIT], 3'b000};
    wire [7:0] dir_view = DIR_RD_ONES | (dir_ff & DIR_WR_MASK);
    wire [7:0] rd_byte = rd_data ? P0_IN : (rd_dir ? dir_view : (rd_cfg ? cfg_view : 8'h00));
    wire rd_hit = rd_data | rd_dir | rd_cfg;

    // Per-pin driver decisions for port 0
    wire port0_pp = cfg_ff[CFG_P0_BIT];
    wire [7:0] nxt_p0_oe;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            wire pin_in = (gi >= HI_NIBBLE_LSB) ? dir_ff[DIR_HI_BIT] : dir_ff[DIR_LO_BIT];
            wire uart_owns = (gi == TOP_PIN) && UART_TX_EN;
            // Open-drain releases a high, push/pull drives it
            assign nxt_p0_oe[gi] = ~pin_in & ~uart_owns & (port0_pp | ~data_ff[gi]);
        end
    endgenerate

    // Write channels
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
        end else begin
            awready_ff <= ~nxt_aw_got;
            wready_ff <= ~nxt_w_got;
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
        end
    end

    // Write address and data capture
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            waddr_ff <= '0;
            wdata_ff <= 8'h00;
            wstrb_ff <= 1'b0;
        end else begin
            if (aw_fire) begin
                waddr_ff <= AWADDR;
            end
            if (w_fire) begin
                wdata_ff <= WDATA[7:0];
                wstrb_ff <= WSTRB[0];
            end
        end
    end

    // Write response
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (b_done) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Register updates; only RESETN reinitialises them, not stop recovery
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cfg_ff <= CFG_RST;
            dir_ff <= DIR_RST;
            data_ff <= PIN_DATA_RST;
        end else begin
            if (wr_cfg & wr_en) begin
                cfg_ff <= nxt_cfg;
            end
            if (wr_dir & wr_en) begin
                dir_ff <= nxt_dir;
            end
            if (wr_data & wr_en) begin
                data_ff <= wdata_ff;
            end
        end
    end

    // Config moves only on a bus write; port 1 direction follows it on large packages
    a_cfg_keep: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        !(wr_cfg && wstrb_ff) |=> $stable(cfg_ff))
        else $error("config changed without a write");

    a_p1_dir_write: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        wr_dir && wstrb_ff && PKG_LARGE |=> PORT1_INPUT == $past(wdata_ff[DIR_P1_BIT]))
        else $error("port 1 direction did not follow write");

    // Read channel
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (ar_fire) begin
                rdata_ff <= {24'h00_0000, rd_byte};
                rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Pin drivers
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            p0_out_ff <= PIN_DATA_RST;
            p0_oe_ff <= 8'h00;
        end else begin
            p0_out_ff <= data_ff;
            p0_oe_ff <= nxt_p0_oe;
        end
    end

    // Open-drain never drives high; pin 7 drives again once the transmitter stops if push/pull with the upper nibble output
    a_od_no_high: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        |(P0_OE & P0_OUT) |-> $past(port0_pp))
        else $error("open-drain port driven high");

    a_pin7_free: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        !$past(UART_TX_EN) && !$past(dir_ff[DIR_HI_BIT]) && $past(port0_pp) |-> P0_OE[TOP_PIN])
        else $error("pin 7 not driven as output");

    // Outputs
    assign AWREADY = awready_ff;
    assign WREADY = wready_ff;
    assign BVALID = bvalid_ff;
    assign BRESP = bresp_ff;
    assign ARREADY = arready_ff;
    assign RVALID = rvalid_ff;
    assign RDATA = rdata_ff;
    assign RRESP = rresp_ff;
    assign P0_OUT = p0_out_ff;
    assign P0_OE = p0_oe_ff;
    assign PORT4_PUSH_PULL = cfg_ff[CFG_P4_BIT];
    assign PORT1_PUSH_PULL = cfg_ff[CFG_P1_BIT];
    assign PORT1_INPUT = dir_ff[DIR_P1_BIT];
    assign CMP_ROUTE_EN = cfg_ff[CFG_CMP_BIT];

    // Checks
    a_p4_mode_write: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        wr_cfg && wstrb_ff && PKG_LARGE |=> PORT4_PUSH_PULL == $past(wdata_ff[3]))
        else $error("port 4 mode did not follow write");

    a_p0_od_high: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        P0_OE[0] && P0_OUT[0] |-> $past(port0_pp))
        else $error("open-drain pin driven high");

    a_p1_mode_write: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        wr_cfg && wstrb_ff && PKG_LARGE |=> PORT1_PUSH_PULL == $past(wdata_ff[1]))
        else $error("port 1 mode did not follow write");

    a_cmp_route_write: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        wr_cfg && wstrb_ff |=> CMP_ROUTE_EN == $past(wdata_ff[0]))
        else $error("comparator route did not follow write");

    a_cfg_read_ones: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        ar_fire && rd_cfg |=> RDATA[7:4] == 4'hF && RDATA[2:0] == 3'b111)
        else $error("config read lost forced ones");

    a_small_pkg_hold: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        wr_cfg && !PKG_LARGE |=> $stable(PORT4_PUSH_PULL) && $stable(PORT1_PUSH_PULL))
        else $error("small package mode bits changed");

    a_hi_nibble_dir: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        |P0_OE[6:4] |-> !$past(dir_ff[DIR_HI_BIT]))
        else $error("upper nibble driven while input");

    a_lo_nibble_dir: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        |P0_OE[3:0] |-> !$past(dir_ff[DIR_LO_BIT]))
        else $error("lower nibble driven while input");

    a_p1_dir_small: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        wr_dir && !PKG_LARGE |=> $stable(PORT1_INPUT))
        else $error("port 1 direction changed on small package");

    a_dir_read_ones: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        ar_fire && rd_dir |=> RDATA[7] && RDATA[5:4] == 2'b11)
        else $error("direction read lost forced ones");

    a_pin_read_level: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        ar_fire && rd_data |=> RDATA[7:0] == $past(P0_IN))
        else $error("data read is not the pin level");

    a_low_drives: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        wr_data && wstrb_ff && !wdata_ff[1] && !dir_ff[DIR_LO_BIT] && !bvalid_ff
        |=> ##1 P0_OE[1] && !P0_OUT[1])
        else $error("written low not driven");

    a_uart_pin7: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        $past(UART_TX_EN) |-> !P0_OE[TOP_PIN])
        else $error("pin 7 driven under UART transmit");

endmodule : pod_port_cfg

`default_nettype wire

/* test/pod_pin_model.sv */
// Board model for the eight port 0 pins.
// Assumes the bench gives the level the board puts on undriven pins.
`timescale 1ns/1ps
`default_nettype none
module pod_pin_model (
    // Device side
    input wire logic [7:0] drv_val,
    input wire logic [7:0] drv_en,
    // Board side
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_lvl
);
    // Driven pins follow the device, released pins show the board
    assign pin_lvl = (drv_en & drv_val) | (~drv_en & ext_val);
endmodule : pod_pin_model
`default_nettype wire

/* test/tb_port_output_mode_and_direction.sv */
// Self-checking bench for the port output mode and direction block.
// Assumes the pin model loops the driven pins back to the pin inputs.
`timescale 1ns/1ps
`default_nettype none
module tb_port_output_mode_and_direction;
    import pod_pkg::*;
    // One row: package, uart, writes, expected pins, flags, read-back
    typedef struct packed {
        logic pkg, uart;
        logic [7:0] cfg, dir, dat, oe;
        logic [3:0] flg;
        logic [7:0] cfgr, dirr;
    } pod_row_t;
    localparam pod_row_t ROWS [4] = '{
        '{1'b1, 1'b0, 8'hF4, 8'hB0, 8'hA5, 8'hFF, 4'h0, 8'hF7, 8'hB0},
        '{1'b1, 1'b1, 8'hFB, 8'hB1, 8'h3C, 8'h40, 4'hD, 8'hFF, 8'hB1},
        '{1'b0, 1'b0, 8'hF0, 8'hB8, 8'h0F, 8'hF0, 4'hC, 8'hFF, 8'hB0},
        '{1'b1, 1'b0, 8'hF4, 8'hF9, 8'hFF, 8'h00, 4'h2, 8'hF7, 8'hF9}
    };
    logic clk = 1'b0, resetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic pkg = 1'b1, uart = 1'b0;
    logic [7:0] ext = 8'h5A;
    wire logic awready, wready, bvalid, arready, rvalid, p4pp, p1pp, p1in, cmp;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0] p0_in, p0_out, p0_oe;
    int mismatches = 0, num_checks = 0;

    pod_port_cfg dut_u (
        .REF_CLK(clk), .RESETN(resetn),
        .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .AWPROT(3'b000),
        .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
        .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
        .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr), .ARPROT(3'b000),
        .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
        .PKG_LARGE(pkg), .UART_TX_EN(uart),
        .P0_IN(p0_in), .P0_OUT(p0_out), .P0_OE(p0_oe),
        .PORT4_PUSH_PULL(p4pp), .PORT1_PUSH_PULL(p1pp), .PORT1_INPUT(p1in), .CMP_ROUTE_EN(cmp)
    );
    pod_pin_model pin_u (.drv_val(p0_out), .drv_en(p0_oe), .ext_val(ext), .pin_lvl(p0_in));

    // Clock at 40 MHz
    initial begin
        forever #12.5 clk = ~clk;
    end

    // Compare and count
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Bus write: address and data offered together, held until taken
    task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] r);
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= s;
        bready <= 1'b1;
        repeat (50) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        chk({bvalid, bresp}, {1'b1, r});
    endtask : axi_wr

    // Bus read: address held until taken, data taken with rvalid
    task automatic axi_rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        repeat (50) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        chk({rvalid, rresp, rdata}, {1'b1, r, 24'h0, d});
    endtask : axi_rd

    // Reset for four cycles, check defaults during and after it
    task automatic do_reset();
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        chk({p0_oe, p4pp, p1pp, p1in, cmp}, 12'h00E);
        resetn <= 1'b1;
        @(posedge clk);
        axi_rd(OFF_CFG, 8'hFF, RESP_OKAY);
        axi_rd(OFF_DIR, 8'hF9, RESP_OKAY);
        $display("reset test done");
    endtask : do_reset

    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    // Cut a hang short; the run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        do_reset();
        foreach (ROWS[i]) begin
            pkg <= ROWS[i].pkg;
            uart <= ROWS[i].uart;
            axi_wr(OFF_CFG, ROWS[i].cfg, 4'h1, RESP_OKAY);
            axi_wr(OFF_DIR, ROWS[i].dir, 4'h1, RESP_OKAY);
            axi_wr(OFF_PIN_DATA, ROWS[i].dat, 4'h1, RESP_OKAY);
            repeat (2) @(posedge clk);
            chk(p0_oe, ROWS[i].oe);
            chk(p0_out & p0_oe, ROWS[i].dat & ROWS[i].oe);
            chk({p4pp, p1pp, p1in, cmp}, ROWS[i].flg);
            axi_rd(OFF_CFG, ROWS[i].cfgr, RESP_OKAY);
            axi_rd(OFF_DIR, ROWS[i].dirr, RESP_OKAY);
            axi_rd(OFF_PIN_DATA, (ROWS[i].dat & ROWS[i].oe) | (ext & ~ROWS[i].oe), RESP_OKAY);
            $display("row %0d done", i);
        end
        // Pin 7 held off the data register while the transmitter runs
        uart <= 1'b1;
        axi_wr(OFF_DIR, 8'hB0, 4'h1, RESP_OKAY);
        axi_wr(OFF_PIN_DATA, 8'h80, 4'h1, RESP_OKAY);
        repeat (2) @(posedge clk);
        chk(p0_oe, 8'h7F);
        uart <= 1'b0;
        repeat (2) @(posedge clk);
        chk({p0_oe, p0_out}, 16'hFF80);
        $display("uart pin test done");
        // Unmapped place and a write without its byte lane
        axi_wr(12'h004, 8'h00, 4'h1, RESP_SLVERR);
        axi_rd(12'h004, 8'h00, RESP_SLVERR);
        axi_wr(OFF_PIN_DATA, 8'h00, 4'h0, RESP_OKAY);
        repeat (2) @(posedge clk);
        chk(p0_out, 8'h80);
        axi_rd(OFF_CFG, 8'hF7, RESP_OKAY);
        $display("bus error test done");
        // Second reset in mid-run
        do_reset();
        report_and_stop();
    end
endmodule : tb_port_output_mode_and_direction
`default_nettype wire
